// >>> bench/cag_addr_gen_assertions.sv
// Port checks of the address generator.
// Assumes a bind onto cag_addr_gen; one clock domain.
`timescale 1ns/1ps
module cag_addr_gen_checker (
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    rst,
   // Decoder side
   input wire logic                    dec_valid,
   input wire logic                    dec_ready,
   input wire logic [7:0]              dec_opcode,
   input wire logic [2:0]              dec_len,
   input wire cag_pkg::cag_pc_mode_type dec_pc_mode,
   input wire logic                    dec_branch_taken,
   input wire logic [7:0]              dec_relative_displacement,
   input wire logic [15:0]             dec_absolute_address_operand,
   input wire logic [7:0]              dec_imm8,
   input wire cag_pkg::cag_ea_mode_type dec_ea_mode,
   // Memory path and results
   input wire logic                    mem_rd_req,
   input wire logic [15:0]             mem_rd_addr,
   input wire logic                    mem_rd_valid,
   input wire logic [7:0]              mem_rd_data,
   input wire logic [15:0]             pc,
   input wire logic                    pc_update,
   input wire logic                    ea_valid,
   input wire logic [15:0]             ea_addr,
   input wire logic                    ea_hs_ram,
   input wire logic                    ea_sfr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire        acc = dec_valid && dec_ready;
   wire        lo  = dec_imm8 < 8'h20;
   wire [15:0] nxt = pc + {13'h0, dec_len};
   wire [15:0] rel = nxt + {{8{dec_relative_displacement[7]}}, dec_relative_displacement};
   wire [15:0] tba = 16'h0040 + {10'h0, dec_opcode[5:1], 1'b0};
   wire [15:0] sha = {7'h7f, lo, dec_imm8};

   AST_SEQ: assert property (acc && dec_pc_mode == cag_pkg::CAG_PC_SEQ |=> pc_update && pc == $past(nxt))
      else $error("sequential pc wrong");
   AST_REL: assert property (acc && dec_pc_mode == cag_pkg::CAG_PC_REL && dec_branch_taken |=> pc == $past(rel))
      else $error("relative target wrong");
   AST_REL_NT: assert property (acc && dec_pc_mode == cag_pkg::CAG_PC_REL && !dec_branch_taken |=> pc == $past(nxt))
      else $error("untaken branch pc wrong");
   AST_IMM: assert property (acc && dec_pc_mode == cag_pkg::CAG_PC_IMM |=> pc == $past(dec_absolute_address_operand))
      else $error("immediate target wrong");
   AST_TBL_ADDR: assert property (acc && dec_pc_mode == cag_pkg::CAG_PC_TABLE |=> mem_rd_req && !dec_ready ##0 mem_rd_addr == $past(tba))
      else $error("table entry address wrong");
   AST_TBL_HI: assert property (mem_rd_req && mem_rd_valid && mem_rd_addr[0] |=> pc_update && dec_ready && pc[15:8] == $past(mem_rd_data))
      else $error("table entry not loaded");
   AST_DIRECT: assert property (acc && dec_ea_mode == cag_pkg::CAG_EA_DIRECT |=> ea_valid && ea_addr == $past(dec_absolute_address_operand))
      else $error("direct address wrong");
   AST_SHORT: assert property (acc && dec_ea_mode == cag_pkg::CAG_EA_SHORT |=> ea_addr == $past(sha) && ea_sfr == $past(lo) && ea_hs_ram != $past(lo))
      else $error("short direct address wrong");
   AST_SFR: assert property (acc && dec_ea_mode == cag_pkg::CAG_EA_SFR |=> ea_sfr && ea_addr == {8'hff, $past(dec_imm8)})
      else $error("special register address wrong");

   cover property (acc && dec_pc_mode == cag_pkg::CAG_PC_TABLE ##[1:40] pc_update);
   cover property (acc && dec_pc_mode == cag_pkg::CAG_PC_REL && dec_branch_taken);
   cover property (acc && dec_ea_mode == cag_pkg::CAG_EA_SHORT && lo);
endmodule

// >>> bench/cag_addr_gen_tb.sv
// Self-checking bench of the address generator.
// Assumes design, checker and memory model compiled first.
`timescale 1ns/1ps
module cag_addr_gen_tb;
   logic                       core_clk, rst, dec_valid, dec_branch_taken, dec_use_func, dec_reg_is_pair;
   logic                       dec_ptr_sel, rf_we, dec_ready, mem_rd_req, mem_rd_valid, pc_update;
   logic                       ea_valid, ea_hs_ram, ea_sfr, ea_is_reg;
   logic [7:0]                 dec_opcode, dec_relative_displacement, dec_imm8, rf_wdata, mem_rd_data;
   logic [2:0]                 dec_len, dec_reg_code, rf_wcode;
   logic [1:0]                 dec_pair_code;
   logic [3:0]                 delay;
   logic [15:0]                dec_absolute_address_operand, mem_rd_addr, pc, ea_addr, ea_reg_value;
   cag_pkg::cag_pc_mode_type   dec_pc_mode;
   cag_pkg::cag_ea_mode_type   dec_ea_mode;
   cag_pkg::cag_reg_func_type  dec_reg_func;
   cag_pkg::cag_pair_func_type dec_pair_func;
   int                         n_fail, samples_checked, cycles;

   cag_addr_gen DUT (.*);
   cag_mem_model u_mem (.*);

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One decoder request, driven at an edge, taken at the next, results read mid-cycle
   task automatic issue(input cag_pkg::cag_pc_mode_type pm, input cag_pkg::cag_ea_mode_type em,
                        input logic [2:0] len, input logic [7:0] d8, input logic [15:0] a16);
      @(posedge core_clk);
      dec_pc_mode <= pm;
      dec_ea_mode <= em;
      dec_len <= len;
      dec_relative_displacement <= d8;
      dec_imm8 <= d8;
      dec_opcode <= d8;
      dec_absolute_address_operand <= a16;
      dec_valid <= 1'b1;
      @(posedge core_clk);
      dec_valid <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic t_seq();
      logic [15:0] e;
      for (int i = 1; i < 4; i++) begin
         e = pc + 16'(i);
         issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_NONE, 3'(i), 8'h00, 16'h0000);
         chk(pc, e);
         chk({14'h0, pc_update, ea_valid}, 16'h0002);
      end
   endtask

   task automatic t_rel();
      issue(cag_pkg::CAG_PC_IMM, cag_pkg::CAG_EA_NONE, 3'h3, 8'h00, 16'hfff0);
      chk(pc, 16'hfff0);
      dec_branch_taken <= 1'b1;
      issue(cag_pkg::CAG_PC_REL, cag_pkg::CAG_EA_NONE, 3'h2, 8'h7f, 16'h0000);
      chk(pc, 16'h0071);
      issue(cag_pkg::CAG_PC_REL, cag_pkg::CAG_EA_NONE, 3'h2, 8'h80, 16'h0000);
      chk(pc, 16'hfff3);
      dec_branch_taken <= 1'b0;
      issue(cag_pkg::CAG_PC_REL, cag_pkg::CAG_EA_NONE, 3'h3, 8'h10, 16'h0000);
      chk(pc, 16'hfff6);
   endtask

   task automatic t_tbl(input logic [4:0] idx, input logic [3:0] dly);
      logic [7:0] a;
      a = 8'h40 + {2'b00, idx, 1'b0};
      delay <= dly;
      issue(cag_pkg::CAG_PC_TABLE, cag_pkg::CAG_EA_NONE, 3'h1, {2'b11, idx, 1'b1}, 16'h0000);
      chk(mem_rd_addr, {8'h00, a});
      chk({15'h0, dec_ready}, 16'h0000);
      for (int i = 0; i < 40 && pc_update !== 1'b1; i++) @(negedge core_clk);
      chk(pc, {(a + 8'h01) ^ 8'h96, a ^ 8'h96});
      chk({14'h0, mem_rd_req, dec_ready}, 16'h0001);
   endtask

   task automatic t_regs();
      logic [7:0] rv [8] = '{8'hcd, 8'hab, 8'h21, 8'h5a, 8'h34, 8'h12, 8'hf0, 8'hff};
      for (int i = 0; i < 8; i++) begin
         rf_we <= 1'b1;
         rf_wcode <= 3'(i);
         rf_wdata <= rv[i];
         @(posedge core_clk);
      end
      rf_we <= 1'b0;
      issue(cag_pkg::CAG_PC_REG, cag_pkg::CAG_EA_NONE, 3'h1, 8'h00, 16'h0000);
      chk(pc, 16'habcd);
      dec_reg_code <= 3'h3;
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_REG, 3'h1, 8'h00, 16'h0000);
      chk({ea_is_reg, ea_reg_value[14:0]}, 16'h805a);
      dec_reg_code <= 3'h0;
      dec_use_func <= 1'b1;
      dec_reg_func <= cag_pkg::CAG_R_B;
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_REG, 3'h1, 8'h00, 16'h0000);
      chk(ea_reg_value, 16'h005a);
      dec_reg_is_pair <= 1'b1;
      dec_pair_func <= cag_pkg::CAG_P_COUNTER_PAIR;
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_REG, 3'h1, 8'h00, 16'h0000);
      chk(ea_reg_value, 16'h5a21);
      dec_use_func <= 1'b0;
      dec_pair_code <= 2'h3;
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_REG, 3'h1, 8'h00, 16'h0000);
      chk(ea_reg_value, 16'hfff0);
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_REG_IND, 3'h1, 8'h00, 16'h0000);
      chk(ea_addr, 16'h1234);
      dec_ptr_sel <= 1'b1;
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_REG_IND, 3'h1, 8'h00, 16'h0000);
      chk(ea_addr, 16'hfff0);
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_BASED, 3'h1, 8'h05, 16'h0000);
      chk(ea_addr, 16'hfff5);
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_BASED, 3'h1, 8'hf0, 16'h0000);
      chk(ea_addr, 16'h00e0);
   endtask

   task automatic t_ea_imm();
      logic [7:0] v [4] = '{8'h00, 8'h1f, 8'h20, 8'hff};
      logic       l;
      issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_DIRECT, 3'h1, 8'h00, 16'h1234);
      chk({ea_valid, ea_addr[14:0]}, 16'h9234);
      foreach (v[i]) begin
         l = v[i] < 8'h20;
         issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_SHORT, 3'h1, v[i], 16'h0000);
         chk(ea_addr, {7'h7f, l, v[i]});
         chk({14'h0, ea_sfr, ea_hs_ram}, {14'h0, l, !l});
         issue(cag_pkg::CAG_PC_SEQ, cag_pkg::CAG_EA_SFR, 3'h1, v[i], 16'h0000);
         chk({ea_sfr, ea_addr[14:0]}, {8'hff, v[i]});
      end
   endtask

   initial begin
      {rst, dec_valid, dec_branch_taken, dec_use_func, dec_reg_is_pair, dec_ptr_sel, rf_we} = 7'h40;
      {dec_opcode, dec_relative_displacement, dec_imm8, rf_wdata} = 32'h0;
      {dec_len, dec_reg_code, rf_wcode, dec_pair_code, delay} = 15'h0;
      dec_absolute_address_operand = 16'h0000;
      dec_pc_mode = cag_pkg::CAG_PC_SEQ;
      dec_ea_mode = cag_pkg::CAG_EA_NONE;
      dec_reg_func = cag_pkg::CAG_R_X;
      dec_pair_func = cag_pkg::CAG_P_ACCUMULATOR_PAIR;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      chk(pc, 16'h0000);
      chk({12'h0, dec_ready, mem_rd_req, pc_update, ea_valid}, 16'h0008);
      t_seq();
      t_rel();
      t_tbl(5'h00, 4'h0);
      t_tbl(5'h1f, 4'h3);
      t_ea_imm();
      t_regs();
      give_verdict();
   end
endmodule

bind cag_addr_gen cag_addr_gen_checker u_chk (
   .core_clk, .rst, .dec_valid, .dec_ready, .dec_opcode, .dec_len, .dec_pc_mode, .dec_branch_taken,
   .dec_relative_displacement, .dec_absolute_address_operand, .dec_imm8, .dec_ea_mode, .mem_rd_req,
   .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .pc, .pc_update, .ea_valid, .ea_addr, .ea_hs_ram, .ea_sfr
);

// >>> bench/cag_mem_model.sv
// Memory read path model serving branch table bytes.
// Assumes one held request level per byte; delay set by the bench.
`timescale 1ns/1ps
module cag_mem_model (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // Answer delay in cycles
   input wire logic [3:0]  delay,
   // Read path
   input wire logic        mem_rd_req,
   input wire logic [15:0] mem_rd_addr,
   output logic            mem_rd_valid,
   output logic [7:0]      mem_rd_data
);
   logic [3:0] cnt_q;
   wire        fire = mem_rd_req && !mem_rd_valid && cnt_q == delay;

   always_ff @(posedge core_clk) begin
      if (rst || !mem_rd_req || mem_rd_valid) cnt_q <= 4'h0;
      else if (cnt_q != delay) cnt_q <= cnt_q + 4'h1;
   end

   always_ff @(posedge core_clk) begin
      mem_rd_valid <= !rst && fire;
      // Table bytes follow the address; idle data toggles
      if (fire) mem_rd_data <= mem_rd_addr[7:0] ^ 8'h96;
      else mem_rd_data <= ~mem_rd_data;
   end
endmodule

// >>> src/cag_addr_gen.sv
// Address generator of the 8-bit core: next program counter and operand addresses.
// Assumes a decoder that holds its fields while dec_valid is high and a memory
// read path that answers each read request with one mem_rd_valid pulse.
`timescale 1ns/1ps
`include "cag_map.svh"

// How it works
// - Sequential fetch adds the instruction's byte count to the program counter.
// - Relative target is next address plus displacement sign-extended from bit 7.
// - Unconditional relative branch and taken conditional branches use the relative target; untaken ones take the next address.
// - Immediate call and branch load the 16-bit instruction address into the counter.
// - Table call uses opcode bits 1 to 5 as index; entry loads the counter.
// - Branch table sits at 40H to 7FH; entries may point anywhere.
// - Register branch loads the counter from the accumulator pair.
// - Direct addressing uses the 16-bit instruction immediate as address.
// - Short direct reaches the 256-byte window FE20H to FF1FH with 8 bits.
// - Window FE20H-FEFFH is high-speed RAM, FF00H-FF1FH is special registers.
// - Short direct address bit 8 is clear for 20H-FFH, set for 00H-1FH.
// - Special register addressing puts 8-bit field as low byte above FF00H.
// - A 3-bit code picks one of eight registers; pairs from four.
// - Absolute and functional register names select the same storage.
// - Register indirect uses one of two pointer pairs as address.
// - Based addressing adds zero-extended 8-bit offset to the base pair.
// - Carry out of the based sum is dropped, wrapping in 64 KB.
module cag_addr_gen (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // Decoder request
   input  wire logic                        dec_valid,
   output logic                             dec_ready,
   input  wire logic [7:0]                  dec_opcode,
   input  wire logic [2:0]                  dec_len,
   input  wire cag_pkg::cag_pc_mode_type    dec_pc_mode,
   input  wire logic                        dec_branch_taken,
   input  wire logic [7:0]                  dec_relative_displacement,
   input  wire logic [15:0]                 dec_absolute_address_operand,
   input  wire logic [7:0]                  dec_imm8,
   input  wire cag_pkg::cag_ea_mode_type    dec_ea_mode,
   input  wire logic                        dec_use_func,
   input  wire logic                        dec_reg_is_pair,
   input  wire logic [2:0]                  dec_reg_code,
   input  wire cag_pkg::cag_reg_func_type   dec_reg_func,
   input  wire logic [1:0]                  dec_pair_code,
   input  wire cag_pkg::cag_pair_func_type  dec_pair_func,
   input  wire logic                        dec_ptr_sel,
   // General register write port
   input  wire logic                        rf_we,
   input  wire logic [2:0]                  rf_wcode,
   input  wire logic [7:0]                  rf_wdata,
   // Memory read path for the branch table
   output logic                             mem_rd_req,
   output logic [15:0]                      mem_rd_addr,
   input  wire logic                        mem_rd_valid,
   input  wire logic [7:0]                  mem_rd_data,
   // Program counter
   output logic [15:0]                      pc,
   output logic                             pc_update,
   // Operand address result
   output logic                             ea_valid,
   output logic [15:0]                      ea_addr,
   output logic                             ea_hs_ram,
   output logic                             ea_sfr,
   output logic                             ea_is_reg,
   output logic [15:0]                      ea_reg_value
);

   cag_pkg::cag_state_type state_q;
   logic [15:0]            pc_q;
   logic                   pc_update_q;
   logic                   ready_q;
   logic                   rd_req_q;
   logic [15:0]            rd_addr_q;
   logic [7:0]             tbl_lo_q;
   logic [7:0]             regs_q [8];
   logic                   ea_valid_q;
   logic [15:0]            ea_addr_q;
   logic                   ea_hs_ram_q;
   logic                   ea_sfr_q;
   logic                   ea_is_reg_q;
   logic [15:0]            ea_reg_value_q;

   logic                   accept;
   logic [15:0]            seq_pc;
   logic [15:0]            rel_pc;
   logic [15:0]            tbl_addr;
   logic [2:0]             reg_sel;
   logic [1:0]             pair_sel;
   logic [15:0]            pair_val [4];
   logic [15:0]            reg_val;

   cag_ea_if ea_bus ();

   cag_ea_unit u_ea (
      .ea (ea_bus.unit)
   );

   assign accept = dec_valid && ready_q;

   // Next sequential address and relative target, both modulo 16 bits
   assign seq_pc = 16'(pc_q + {13'h0000, dec_len});
   assign rel_pc = 16'(seq_pc + {{8{dec_relative_displacement[`CAG_DISP_SIGN]}},
                                 dec_relative_displacement});

   // Two-byte entry per index inside 40H..7FH
   assign tbl_addr = 16'(`CAG_TBL_BASE
                        + {10'h000, dec_opcode[`CAG_TBL_IDX_MSB:`CAG_TBL_IDX_LSB], 1'b0});

   // Absolute code or functional name, one storage
   assign reg_sel  = dec_use_func ? 3'(dec_reg_func) : dec_reg_code;
   assign pair_sel = dec_use_func ? 2'(dec_pair_func) : dec_pair_code;

   // Pair n is the odd register high, even register low
   generate
      for (genvar p = 0; p < 4; p++) begin : g_pair
         assign pair_val[p] = {regs_q[2*p+1], regs_q[2*p]};
      end
   endgenerate

   assign reg_val = dec_reg_is_pair ? pair_val[pair_sel] : {8'h00, regs_q[reg_sel]};

   // Effective address unit inputs
   assign ea_bus.mode         = dec_ea_mode;
   assign ea_bus.imm8         = dec_imm8;
   assign ea_bus.imm16        = dec_absolute_address_operand;
   assign ea_bus.base_pair    = pair_val[`CAG_PAIR_BASE];
   assign ea_bus.pointer_pair = dec_ptr_sel ? pair_val[`CAG_PAIR_BASE]
                                            : pair_val[`CAG_PAIR_SEC];

   // General registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            regs_q[i] <= `CAG_REG_RESET;
         end
      end else if (rf_we) begin
         regs_q[rf_wcode] <= rf_wdata;
      end
   end

   // Table call sequencer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= cag_pkg::CAG_ST_IDLE;
      end else begin
         case (state_q)
            cag_pkg::CAG_ST_IDLE: begin
               if (accept && dec_pc_mode == cag_pkg::CAG_PC_TABLE) begin
                  state_q <= cag_pkg::CAG_ST_TBL_LO;
               end
            end
            cag_pkg::CAG_ST_TBL_LO: begin
               if (mem_rd_valid) begin
                  state_q <= cag_pkg::CAG_ST_TBL_HI;
               end
            end
            cag_pkg::CAG_ST_TBL_HI: begin
               if (mem_rd_valid) begin
                  state_q <= cag_pkg::CAG_ST_IDLE;
               end
            end
            default: begin
               state_q <= cag_pkg::CAG_ST_IDLE;
            end
         endcase
      end
   end

   // Decoder handshake: busy for the table fetch
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ready_q <= 1'b1;
      end else if (accept && dec_pc_mode == cag_pkg::CAG_PC_TABLE) begin
         ready_q <= 1'b0;
      end else if (state_q == cag_pkg::CAG_ST_TBL_HI && mem_rd_valid) begin
         ready_q <= 1'b1;
      end
   end

   // Table read requests, low byte then high byte
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_req_q  <= 1'b0;
         rd_addr_q <= `CAG_ADDR_RESET;
         tbl_lo_q  <= `CAG_REG_RESET;
      end else if (accept && dec_pc_mode == cag_pkg::CAG_PC_TABLE) begin
         rd_req_q  <= 1'b1;
         rd_addr_q <= tbl_addr;
      end else if (state_q == cag_pkg::CAG_ST_TBL_LO && mem_rd_valid) begin
         tbl_lo_q  <= mem_rd_data;
         rd_addr_q <= 16'(rd_addr_q + 16'h0001);
      end else if (state_q == cag_pkg::CAG_ST_TBL_HI && mem_rd_valid) begin
         rd_req_q  <= 1'b0;
      end
   end

   // Program counter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pc_q        <= `CAG_PC_RESET;
         pc_update_q <= 1'b0;
      end else begin
         pc_update_q <= 1'b0;
         if (accept) begin
            case (dec_pc_mode)
               cag_pkg::CAG_PC_SEQ: begin
                  pc_q        <= seq_pc;
                  pc_update_q <= 1'b1;
               end
               cag_pkg::CAG_PC_REL: begin
                  // Not-taken conditional branch falls through
                  pc_q        <= dec_branch_taken ? rel_pc : seq_pc;
                  pc_update_q <= 1'b1;
               end
               cag_pkg::CAG_PC_IMM: begin
                  pc_q        <= dec_absolute_address_operand;
                  pc_update_q <= 1'b1;
               end
               cag_pkg::CAG_PC_REG: begin
                  pc_q        <= pair_val[`CAG_PAIR_ACC];
                  pc_update_q <= 1'b1;
               end
               cag_pkg::CAG_PC_TABLE: begin
                  pc_q <= pc_q;
               end
               default: begin
                  pc_q        <= seq_pc;
                  pc_update_q <= 1'b1;
               end
            endcase
         end else if (state_q == cag_pkg::CAG_ST_TBL_HI && mem_rd_valid) begin
            pc_q        <= {mem_rd_data, tbl_lo_q};
            pc_update_q <= 1'b1;
         end
      end
   end

   // Operand address result
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ea_valid_q     <= 1'b0;
         ea_addr_q      <= `CAG_ADDR_RESET;
         ea_hs_ram_q    <= 1'b0;
         ea_sfr_q       <= 1'b0;
         ea_is_reg_q    <= 1'b0;
         ea_reg_value_q <= `CAG_ADDR_RESET;
      end else begin
         ea_valid_q <= accept && (dec_ea_mode != cag_pkg::CAG_EA_NONE);
         if (accept) begin
            ea_addr_q      <= ea_bus.ea_addr;
            ea_hs_ram_q    <= ea_bus.ea_hs_ram;
            ea_sfr_q       <= ea_bus.ea_sfr;
            ea_is_reg_q    <= (dec_ea_mode == cag_pkg::CAG_EA_REG);
            ea_reg_value_q <= reg_val;
         end
      end
   end

   assign dec_ready    = ready_q;
   assign mem_rd_req   = rd_req_q;
   assign mem_rd_addr  = rd_addr_q;
   assign pc           = pc_q;
   assign pc_update    = pc_update_q;
   assign ea_valid     = ea_valid_q;
   assign ea_addr      = ea_addr_q;
   assign ea_hs_ram    = ea_hs_ram_q;
   assign ea_sfr       = ea_sfr_q;
   assign ea_is_reg    = ea_is_reg_q;
   assign ea_reg_value = ea_reg_value_q;

endmodule

// >>> src/cag_ea_if.sv
// Carrier between the address generator and its effective address unit.
// Assumes cag_pkg compiled first.
`timescale 1ns/1ps
interface cag_ea_if;
   cag_pkg::cag_ea_mode_type mode;
   logic [7:0]               imm8;
   logic [15:0]              imm16;
   logic [15:0]              base_pair;
   logic [15:0]              pointer_pair;
   logic [15:0]              ea_addr;
   logic                     ea_hs_ram;
   logic                     ea_sfr;

   modport unit (
      input  mode,
      input  imm8,
      input  imm16,
      input  base_pair,
      input  pointer_pair,
      output ea_addr,
      output ea_hs_ram,
      output ea_sfr
   );

   modport user (
      output mode,
      output imm8,
      output imm16,
      output base_pair,
      output pointer_pair,
      input  ea_addr,
      input  ea_hs_ram,
      input  ea_sfr
   );
endinterface

// >>> src/cag_ea_unit.sv
// Combinational operand effective address unit.
// Assumes the user side registers its results.
`timescale 1ns/1ps
`include "cag_map.svh"
module cag_ea_unit (
   cag_ea_if.unit ea
);

   always_comb begin
      ea.ea_addr   = `CAG_ADDR_RESET;
      ea.ea_hs_ram = 1'b0;
      ea.ea_sfr    = 1'b0;
      case (ea.mode)
         cag_pkg::CAG_EA_DIRECT: begin
            ea.ea_addr = ea.imm16;
         end
         cag_pkg::CAG_EA_SHORT: begin
            // Bit 8 set only for the low 20H values
            ea.ea_addr   = {`CAG_SHORT_HI, (ea.imm8 < `CAG_SHORT_RAM_MIN), ea.imm8};
            ea.ea_hs_ram = (ea.imm8 >= `CAG_SHORT_RAM_MIN);
            ea.ea_sfr    = (ea.imm8 < `CAG_SHORT_RAM_MIN);
         end
         cag_pkg::CAG_EA_SFR: begin
            ea.ea_addr = {`CAG_SFR_HI, ea.imm8};
            ea.ea_sfr  = 1'b1;
         end
         cag_pkg::CAG_EA_REG_IND: begin
            ea.ea_addr = ea.pointer_pair;
         end
         cag_pkg::CAG_EA_BASED: begin
            // Carry out of bit 15 falls off the 16-bit result
            ea.ea_addr = 16'(ea.base_pair + {8'h00, ea.imm8});
         end
         default: begin
            ea.ea_addr = `CAG_ADDR_RESET;
         end
      endcase
   end

endmodule

// >>> src/cag_map.svh
// Constants of the address generation block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the design modules.
`ifndef CAG_MAP_SVH
`define CAG_MAP_SVH

// Reset values
`define CAG_PC_RESET       16'h0000
`define CAG_REG_RESET      8'h00
`define CAG_ADDR_RESET     16'h0000

// Relative branch displacement sign position
`define CAG_DISP_SIGN      7

// Table call: index field in the opcode and table base
`define CAG_TBL_IDX_LSB    1
`define CAG_TBL_IDX_MSB    5
`define CAG_TBL_BASE       16'h0040

// Short direct window: upper seven bits and lowest RAM byte value
`define CAG_SHORT_HI       7'h7f
`define CAG_SHORT_RAM_MIN  8'h20

// Special function register page
`define CAG_SFR_HI         8'hff

// Register pair codes
`define CAG_PAIR_ACC       2'h0
`define CAG_PAIR_CNT       2'h1
`define CAG_PAIR_SEC       2'h2
`define CAG_PAIR_BASE      2'h3

`endif

// >>> src/cag_pkg.sv
// Types of the address generation block.
// Assumes cag_map.svh alongside for numeric constants.
package cag_pkg;

   // Program counter source chosen by the decoder
   typedef enum logic [2:0] {
      CAG_PC_SEQ,
      CAG_PC_REL,
      CAG_PC_IMM,
      CAG_PC_TABLE,
      CAG_PC_REG
   } cag_pc_mode_type;

   // Operand addressing mode
   typedef enum logic [2:0] {
      CAG_EA_NONE,
      CAG_EA_DIRECT,
      CAG_EA_SHORT,
      CAG_EA_SFR,
      CAG_EA_REG,
      CAG_EA_REG_IND,
      CAG_EA_BASED
   } cag_ea_mode_type;

   // Functional names of the eight general registers, same codes as absolute names
   typedef enum logic [2:0] {
      CAG_R_X,
      CAG_R_A,
      CAG_R_C,
      CAG_R_B,
      CAG_R_E,
      CAG_R_D,
      CAG_R_L,
      CAG_R_H
   } cag_reg_func_type;

   // Functional names of the four register pairs
   typedef enum logic [1:0] {
      CAG_P_ACCUMULATOR_PAIR,
      CAG_P_COUNTER_PAIR,
      CAG_P_SECOND_POINTER_PAIR,
      CAG_P_BASE_POINTER_PAIR
   } cag_pair_func_type;

   // Table call sequencer states
   typedef enum logic [1:0] {
      CAG_ST_IDLE,
      CAG_ST_TBL_LO,
      CAG_ST_TBL_HI
   } cag_state_type;

endpackage
